// ==== common/cmh_params.svh ====
// Purpose: constants for the can mailbox message handler
// Assumes: 8 mailboxes, AHB-Lite register access
// Notes: Operation list below
// Operation
// - lowest-numbered eligible receive mailbox takes message
// - priority ignored for receive modes
// - full plain receive mailbox passes message on
// - transmit mode starts with ready set
// - transfer request clears ready until sent/aborted
// - pending interrupt while ready, masked per mailbox
// - remote bit requests remote frame
// - smallest priority value transmits first
// - equal priority, lowest mailbox first
// - global transfer command raises several requests
// - abort per mailbox or global abort command
// - abort on bus sets ready only
// - lost arbitration retried automatically
// - retry disabled aborts after first failure
// - producer sends only after remote frame
// - producer remote frame while ready sets ignored
// - consumer sends remote frame, ready on answer
// - consumer keeps first answer, flags later ones that no other mailbox takes
// - eight independent mailboxes
// - receive transfer request rearms mailbox
`ifndef CMH_PARAMS_SVH
`define CMH_PARAMS_SVH
`define CMH_NUM_MB 8
`define CMH_MB_STRIDE 12'h020
`define CMH_MB_BASE 12'h200
`define CMH_OFF_MR 12'h000
`define CMH_OFF_IMR 12'h00C
`define CMH_OFF_IER 12'h004
`define CMH_OFF_IDR 12'h008
`define CMH_OFF_TCR 12'h024
`define CMH_OFF_ACR 12'h028
`define CMH_MB_MMR 5'h00
`define CMH_MB_MSR 5'h10
`define CMH_MB_MDL 5'h14
`define CMH_MB_MDH 5'h18
`define CMH_MB_MCR 5'h1C
`define CMH_MR_RETRY_DISABLE 7
`define CMH_MMR_PRI_LSB 16
`define CMH_MMR_MOT_LSB 24
`define CMH_MCR_DLC_LSB 16
`define CMH_MCR_RTR 20
`define CMH_MCR_ACR 22
`define CMH_MCR_TCR 23
`define CMH_MSR_ABT 22
`define CMH_MSR_RDY 23
`define CMH_MSR_MMI 24
`define CMH_MSR_RTR 20
`define CMH_MSR_DLC_LSB 16
`endif

// ==== common/cmh_pkg.sv ====
// Purpose: types for the can mailbox message handler
// Assumes: included constants
// Notes: mode codes are local
package cmh_pkg;
  typedef enum logic [2:0] {
    CMH_MOT_DIS = 3'b000,
    CMH_MOT_RX = 3'b001,
    CMH_MOT_RXOVR = 3'b010,
    CMH_MOT_TX = 3'b011,
    CMH_MOT_CONS = 3'b100,
    CMH_MOT_PROD = 3'b101
  } cmh_mot_t;
  typedef struct packed {
    logic valid;
    logic [2:0] mb;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } cmh_frame_t;
endpackage : cmh_pkg

// ==== rtl/cmh_pick.sv ====
`timescale 1ns/1ns
// Purpose: choose lowest index, optionally by priority key
// Assumes: key zero when priority unused
// Notes: combinational, less-or-equal compare scanning downward keeps low index on ties
module cmh_pick #(
  parameter int N = 8
) (
  input wire logic [N-1:0] req,
  input wire logic [N*4-1:0] key,
  output logic found,
  output logic [$clog2(N)-1:0] idx
);
  // scan from top so lower index with equal key wins
  always_comb begin
    logic [3:0] best;
    best = 4'hF;
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!found || key[i*4 +: 4] <= best)) begin
        found = 1'b1;
        best = key[i*4 +: 4];
        idx = i[$clog2(N)-1:0];
      end
    end
  end
endmodule : cmh_pick

// ==== rtl/cmh_ahb.sv ====
`timescale 1ns/1ns
// Purpose: ahb-lite slave front end, zero wait state
// Assumes: single word transfers
// Notes: write strobe issued in data phase
module cmh_ahb (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic wr_en,
  output logic rd_en,
  output logic [11:0] addr
);
  logic wr_q;
  logic rd_q;
  logic [11:0] addr_q;
  wire take = hsel && hready && htrans[1];
  // latch address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      addr_q <= take ? haddr : addr_q;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = wr_q;
  assign rd_en = rd_q;
  assign addr = addr_q;
endmodule : cmh_ahb

// ==== rtl/cmh_top.sv ====
`timescale 1ns/1ns
// Purpose: mailbox handling: receive chaining, transmit arbitration, abort, remote frames
// Assumes: protocol engine offers one frame at a time and reports win/loss/done
// Notes: acceptance filtering is done by the engine; it flags matching mailboxes
`include "cmh_params.svh"
module cmh_top
  import cmh_pkg::*;
#(
  parameter int NMB = `CMH_NUM_MB
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_valid,
  input wire logic [NMB-1:0] rx_match,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic eng_idle,
  output cmh_frame_t tx_frame,
  input wire logic tx_take,
  input wire logic tx_won,
  input wire logic tx_lost,
  input wire logic tx_done,
  output logic [NMB-1:0] mb_irq
);
  localparam int IW = $clog2(NMB);
  logic wr_en;
  logic rd_en;
  logic [11:0] addr;
  cmh_ahb u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr)
  );
  // per mailbox state
  cmh_mot_t mot_q [NMB];
  logic [3:0] pri_q [NMB];
  logic [NMB-1:0] rdy_q;
  logic [NMB-1:0] mmi_q;
  logic [NMB-1:0] abt_q;
  logic [NMB-1:0] pend_q;
  logic [NMB-1:0] rtr_q;
  logic [NMB-1:0] got_rf_q;
  logic [3:0] dlc_q [NMB];
  logic [63:0] data_q [NMB];
  logic [NMB-1:0] imr_q;
  logic retry_disable_q;
  // engine-facing transfer state
  logic busy_q;
  logic onbus_q;
  logic [IW-1:0] cur_q;
  logic [31:0] hrdata_q;
  // address decode
  wire is_mb = addr >= `CMH_MB_BASE && addr < (`CMH_MB_BASE + 12'(NMB) * `CMH_MB_STRIDE);
  wire [11:0] mb_off = addr - `CMH_MB_BASE;
  wire [IW-1:0] amb = mb_off[5 +: IW];
  wire [4:0] areg = mb_off[4:0];
  wire w_mr = wr_en && addr == `CMH_OFF_MR;
  wire w_ier = wr_en && addr == `CMH_OFF_IER;
  wire w_idr = wr_en && addr == `CMH_OFF_IDR;
  wire w_tcr = wr_en && addr == `CMH_OFF_TCR;
  wire w_acr = wr_en && addr == `CMH_OFF_ACR;
  wire w_mmr = wr_en && is_mb && areg == `CMH_MB_MMR;
  wire w_mcr = wr_en && is_mb && areg == `CMH_MB_MCR;
  wire w_mdl = wr_en && is_mb && areg == `CMH_MB_MDL;
  wire w_mdh = wr_en && is_mb && areg == `CMH_MB_MDH;
  wire r_msr = rd_en && is_mb && areg == `CMH_MB_MSR;
  // command vectors: global and per-mailbox combined
  logic [NMB-1:0] tcr_vec;
  logic [NMB-1:0] acr_vec;
  logic [NMB-1:0] rtr_req;
  always_comb begin
    tcr_vec = w_tcr ? hwdata[NMB-1:0] : '0;
    acr_vec = w_acr ? hwdata[NMB-1:0] : '0;
    rtr_req = '0;
    if (w_mcr) begin
      tcr_vec[amb] = tcr_vec[amb] | hwdata[`CMH_MCR_TCR];
      acr_vec[amb] = acr_vec[amb] | hwdata[`CMH_MCR_ACR];
      rtr_req[amb] = hwdata[`CMH_MCR_RTR];
    end
  end
  // receive acceptance: full plain receive/consumer boxes refuse; producers take remote frames even when ready
  logic [NMB-1:0] rx_elig;
  logic [NMB*4-1:0] zero_key;
  always_comb begin
    zero_key = '0; // priority has no say in reception
    for (int i = 0; i < NMB; i++) begin
      unique case (mot_q[i])
        CMH_MOT_RX: rx_elig[i] = rx_match[i] && !rx_rtr && !rdy_q[i];
        CMH_MOT_RXOVR: rx_elig[i] = rx_match[i] && !rx_rtr;
        CMH_MOT_CONS: rx_elig[i] = rx_match[i] && !rx_rtr && got_rf_q[i] && !rdy_q[i];
        CMH_MOT_PROD: rx_elig[i] = rx_match[i] && rx_rtr;
        default: rx_elig[i] = 1'b0;
      endcase
    end
  end
  logic rx_found;
  logic [IW-1:0] rx_idx;
  cmh_pick #(.N(NMB)) u_rx_pick (
    .req(rx_elig),
    .key(zero_key),
    .found(rx_found),
    .idx(rx_idx)
  );
  // matching messages refused because a box is still full
  logic [NMB-1:0] rx_lost;
  always_comb begin
    for (int i = 0; i < NMB; i++) begin
      rx_lost[i] = rx_valid && !rx_found && rx_match[i] && !rx_rtr && rdy_q[i] &&
                   (mot_q[i] == CMH_MOT_RX || mot_q[i] == CMH_MOT_CONS);
    end
  end
  wire rx_hit = rx_valid && rx_found;
  wire rx_prod = rx_hit && mot_q[rx_idx] == CMH_MOT_PROD;
  // transmit candidates: producers only once a remote frame came
  logic [NMB-1:0] tx_elig;
  logic [NMB*4-1:0] tx_key;
  always_comb begin
    for (int i = 0; i < NMB; i++) begin
      tx_key[i*4 +: 4] = pri_q[i];
      tx_elig[i] = pend_q[i] && (mot_q[i] != CMH_MOT_PROD || got_rf_q[i]);
    end
  end
  logic tx_found;
  logic [IW-1:0] tx_idx;
  // re-picked every time the engine is free, so new urgent work pre-empts retries
  cmh_pick #(.N(NMB)) u_tx_pick (
    .req(tx_elig),
    .key(tx_key),
    .found(tx_found),
    .idx(tx_idx)
  );
  wire launch = tx_found && !busy_q && eng_idle;
  wire fin_ok = busy_q && tx_done;
  wire fin_lost = busy_q && tx_lost;
  wire consumer_cur = mot_q[cur_q] == CMH_MOT_CONS;
  // offered frame, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_frame <= '0;
    end else if (launch) begin
      tx_frame.valid <= 1'b1;
      tx_frame.mb <= 3'(tx_idx);
      tx_frame.rtr <= rtr_q[tx_idx] || mot_q[tx_idx] == CMH_MOT_CONS;
      tx_frame.dlc <= dlc_q[tx_idx];
      tx_frame.data <= data_q[tx_idx];
    end else if (tx_take || fin_ok || fin_lost || (busy_q && !pend_q[cur_q])) begin
      // an aborted box withdraws its offer; a frame already on the bus still completes
      tx_frame.valid <= 1'b0;
    end
  end
  // engine transfer tracking; on-bus once arbitration won
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      onbus_q <= 1'b0;
      cur_q <= '0;
    end else begin
      if (launch) begin
        busy_q <= 1'b1;
        cur_q <= tx_idx;
      end else if (fin_ok || fin_lost || (busy_q && !pend_q[cur_q])) begin
        busy_q <= 1'b0;
      end
      if (busy_q && tx_won) begin
        onbus_q <= 1'b1;
      end else if (!busy_q || fin_ok || fin_lost) begin
        onbus_q <= 1'b0;
      end
    end
  end
  // per-mailbox flags; hardware set beats software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_q <= '0;
      mmi_q <= '0;
      abt_q <= '0;
      pend_q <= '0;
      rtr_q <= '0;
      got_rf_q <= '0;
      imr_q <= '0;
      retry_disable_q <= 1'b0;
      for (int i = 0; i < NMB; i++) begin
        mot_q[i] <= CMH_MOT_DIS;
        pri_q[i] <= 4'h0;
        dlc_q[i] <= 4'h0;
        data_q[i] <= 64'h0000_0000_0000_0000;
      end
    end else begin
      if (w_mr) retry_disable_q <= hwdata[`CMH_MR_RETRY_DISABLE];
      if (w_ier) imr_q <= imr_q | hwdata[NMB-1:0];
      if (w_idr) imr_q <= imr_q & ~hwdata[NMB-1:0];
      if (w_mdl) data_q[amb][31:0] <= hwdata;
      if (w_mdh) data_q[amb][63:32] <= hwdata;
      for (int i = 0; i < NMB; i++) begin
        if (r_msr && amb == i[IW-1:0]) mmi_q[i] <= 1'b0;
        if (w_mmr && amb == i[IW-1:0]) begin
          mot_q[i] <= cmh_mot_t'(hwdata[`CMH_MMR_MOT_LSB +: 3]);
          pri_q[i] <= hwdata[`CMH_MMR_PRI_LSB +: 4];
          pend_q[i] <= 1'b0;
          abt_q[i] <= 1'b0;
          got_rf_q[i] <= 1'b0;
          // transmit and producer start ready, others start empty
          rdy_q[i] <= hwdata[`CMH_MMR_MOT_LSB +: 3] == CMH_MOT_TX ||
                      hwdata[`CMH_MMR_MOT_LSB +: 3] == CMH_MOT_PROD;
        end else if (tcr_vec[i] && mot_q[i] != CMH_MOT_DIS) begin
          rdy_q[i] <= 1'b0;
          abt_q[i] <= 1'b0;
          got_rf_q[i] <= 1'b0;
          if (mot_q[i] == CMH_MOT_TX || mot_q[i] == CMH_MOT_PROD ||
              mot_q[i] == CMH_MOT_CONS) begin
            pend_q[i] <= 1'b1;
            if (w_mcr && amb == i[IW-1:0]) begin
              dlc_q[i] <= hwdata[`CMH_MCR_DLC_LSB +: 4];
              rtr_q[i] <= rtr_req[i] && mot_q[i] == CMH_MOT_TX;
            end
          end
        end else if (acr_vec[i] && pend_q[i]) begin
          pend_q[i] <= 1'b0;
          rdy_q[i] <= 1'b1;
          abt_q[i] <= !(busy_q && onbus_q && cur_q == i[IW-1:0]);
        end
        // received frame lands in the chosen box
        if (rx_hit && rx_idx == i[IW-1:0]) begin
          if (mot_q[i] == CMH_MOT_PROD) begin
            if (rdy_q[i]) mmi_q[i] <= 1'b1;
            else got_rf_q[i] <= 1'b1;
          end else begin
            if (rdy_q[i]) mmi_q[i] <= 1'b1; // overwrite drops older
            rdy_q[i] <= 1'b1;
            dlc_q[i] <= rx_dlc;
            data_q[i] <= rx_data;
            got_rf_q[i] <= 1'b0;
          end
        end
        if (rx_lost[i]) mmi_q[i] <= 1'b1;
        // transfer end for the current box
        if (busy_q && cur_q == i[IW-1:0] && pend_q[i]) begin
          if (fin_ok) begin
            pend_q[i] <= 1'b0;
            if (consumer_cur) got_rf_q[i] <= 1'b1; // wait for answer
            else rdy_q[i] <= 1'b1;
          end else if (fin_lost && retry_disable_q) begin
            pend_q[i] <= 1'b0;
            rdy_q[i] <= 1'b1;
            abt_q[i] <= 1'b1;
          end // otherwise stays pending for retry
        end
      end
    end
  end
  // read mux, combinational; unmapped reads give zero
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (addr == `CMH_OFF_MR) rd_d[`CMH_MR_RETRY_DISABLE] = retry_disable_q;
    else if (addr == `CMH_OFF_IMR) rd_d[NMB-1:0] = imr_q;
    else if (is_mb) begin
      unique case (areg)
        `CMH_MB_MMR: begin
          rd_d[`CMH_MMR_MOT_LSB +: 3] = mot_q[amb];
          rd_d[`CMH_MMR_PRI_LSB +: 4] = pri_q[amb];
        end
        `CMH_MB_MSR: begin
          rd_d[`CMH_MSR_RDY] = rdy_q[amb];
          rd_d[`CMH_MSR_MMI] = mmi_q[amb];
          rd_d[`CMH_MSR_ABT] = abt_q[amb];
          rd_d[`CMH_MSR_RTR] = rtr_q[amb];
          rd_d[`CMH_MSR_DLC_LSB +: 4] = dlc_q[amb];
        end
        `CMH_MB_MDL: rd_d = data_q[amb][31:0];
        `CMH_MB_MDH: rd_d = data_q[amb][63:32];
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end
  // data phase is the cycle after address phase, so sample the live decode there
  assign hrdata = rd_en ? rd_d : 32'h0000_0000;
  // level interrupt per mailbox while ready and unmasked
  assign mb_irq = rdy_q & imr_q;
endmodule : cmh_top

// ==== test/cmh_props.sv ====
// Purpose: port checker for cmh_top
// Assumes: zero wait bus slave, one clock
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module cmh_props
  import cmh_pkg::*;
#(
  parameter int NMB = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic eng_idle,
  input wire cmh_frame_t tx_frame,
  input wire logic tx_take,
  input wire logic tx_won,
  input wire logic tx_lost,
  input wire logic tx_done,
  input wire logic [NMB-1:0] mb_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_q;
  logic [11:0] a_q;
  wire hold_w = tx_frame.valid & ~tx_take & ~tx_done & ~tx_lost;
  // read data phase tracker; hrdata must be zero outside it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      a_q <= 12'h000;
    end else if (hready) begin
      rd_q <= hsel & htrans[1] & ~hwrite;
      a_q <= haddr;
    end
  end
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_unmapped_zero: assert property (rd_q && a_q == 12'h100 |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_frame_valid_holds: assert property (hold_w |=> tx_frame.valid)
    else $error("frame offer withdrawn");
  a_frame_stable: assert property (hold_w |=> $stable(tx_frame))
    else $error("offered frame changed");
  a_launch_when_idle: assert property ($rose(tx_frame.valid) |-> $past(eng_idle))
    else $error("frame offered to busy engine");
  a_irq_reset_clear: assert property ($rose(hresetn) |-> mb_irq == '0)
    else $error("interrupt after reset");
  c_won: cover property (tx_won);
  c_lost: cover property (tx_lost);
  c_irq: cover property ($rose(|mb_irq));
endmodule : cmh_props

bind cmh_top cmh_props #(.NMB(NMB)) u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .eng_idle(eng_idle), .tx_frame(tx_frame),
  .tx_take(tx_take), .tx_won(tx_won), .tx_lost(tx_lost), .tx_done(tx_done), .mb_irq(mb_irq));

// ==== test/cmh_eng_model.sv ====
// Purpose: behavioural protocol engine facing the mailboxes
// Assumes: one frame in flight, arbitration and completion delays of dly cycles, set by the bench
// Notes: lose_n forces lost arbitrations; log_q keeps {rtr,mb} sent
`timescale 1ns/1ns
module cmh_eng_model
  import cmh_pkg::*;
(
  input wire logic hclk,
  input wire cmh_frame_t tx_frame,
  output logic rx_valid,
  output logic [7:0] rx_match,
  output logic rx_rtr,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data,
  output logic eng_idle,
  output logic tx_take,
  output logic tx_won,
  output logic tx_lost,
  output logic tx_done
);
  int dly = 3;
  int lose_n = 0;
  logic [3:0] log_q[$];
  logic [3:0] cur;
  bit won;
  initial begin
    {rx_valid, rx_match, rx_rtr, rx_dlc, rx_data} = '0;
    {tx_take, tx_won, tx_lost, tx_done} = 4'h0;
    eng_idle = 1'b1;
  end
  // one received frame; fields other than dlc turn over after release so stale data is not seen
  task automatic rx(input logic [7:0] m, input logic r, input logic [63:0] d);
    @(posedge hclk);
    {rx_valid, rx_match, rx_rtr, rx_dlc, rx_data} <= {1'b1, m, r, 4'h8, d};
    @(posedge hclk);
    {rx_valid, rx_match, rx_rtr, rx_data} <= {1'b0, ~m, ~r, ~d};
  endtask : rx
  // arbitration: lost frames go back to the selector, won frames finish later
  always begin
    @(posedge hclk);
    if (tx_frame.valid === 1'b1 && eng_idle) begin
      cur = {tx_frame.rtr, tx_frame.mb};
      eng_idle <= 1'b0;
      repeat (dly) @(posedge hclk);
      won = (lose_n == 0);
      if (!won) lose_n--;
      {tx_lost, tx_take, tx_won} <= {!won, won, won};
      @(posedge hclk);
      {tx_lost, tx_take, tx_won} <= 3'b000;
      if (won) begin
        repeat (dly) @(posedge hclk);
        tx_done <= 1'b1;
        log_q.push_back(cur);
        @(posedge hclk);
        tx_done <= 1'b0;
      end
      eng_idle <= 1'b1;
    end
  end
endmodule : cmh_eng_model

// ==== test/tb_can_mailbox_message_handler.sv ====
// Purpose: self-checking bench for the mailbox handler
// Assumes: zero wait bus slave, engine model on the far side
// Notes: scenarios run back to back after one reset
`timescale 1ns/1ns
`include "cmh_params.svh"
module tb_can_mailbox_message_handler import cmh_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, rx_valid, rx_rtr, eng_idle, tx_take, tx_won, tx_lost, tx_done;
  logic [7:0] rx_match, mb_irq;
  logic [3:0] rx_dlc;
  logic [63:0] rx_data;
  cmh_frame_t tx_frame;
  int mismatches = 0;
  int comparisons = 0;
  always #4 hclk = ~hclk;
  cmh_top #(.NMB(8)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid),
    .rx_match(rx_match), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .eng_idle(eng_idle), .tx_frame(tx_frame), .tx_take(tx_take), .tx_won(tx_won),
    .tx_lost(tx_lost), .tx_done(tx_done), .mb_irq(mb_irq));
  cmh_eng_model u_eng (.hclk(hclk), .tx_frame(tx_frame), .rx_valid(rx_valid),
    .rx_match(rx_match), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .eng_idle(eng_idle), .tx_take(tx_take), .tx_won(tx_won), .tx_lost(tx_lost),
    .tx_done(tx_done));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task automatic fail(input string s);
    mismatches++;
    $display("Error %0t %s", $time, s);
    conclude();
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // edge by edge until the slave shows ready, bounded
  task automatic waitr();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) fail("bus hang");
  endtask : waitr
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'b10};
    waitr();
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    waitr();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    bus(a, 1'b0, 32'h0000_0000);
  endtask : rd
  function automatic logic [11:0] ma(input int n, input logic [4:0] o);
    return 12'(`CMH_MB_BASE + `CMH_MB_STRIDE * n + o);
  endfunction : ma
  task automatic mode(input int n, input cmh_mot_t m, input logic [3:0] p);
    wr(ma(n, `CMH_MB_MMR), {5'h00, m, 4'h0, p, 16'h0000});
  endtask : mode
  // status bits {ignored, ready, aborted} under a care mask
  task automatic st(input int n, input logic [2:0] e, input logic [2:0] m);
    rd(ma(n, `CMH_MB_MSR));
    chk({29'h0, q[24:22] & m}, {29'h0, e});
  endtask : st
  task automatic wl(input int k);
    int n;
    for (n = 0; n < 400 && u_eng.log_q.size() < k; n++) @(posedge hclk);
    if (u_eng.log_q.size() < k) fail("no frame");
  endtask : wl
  task automatic wev(input bit w);
    int n;
    for (n = 0; n < 400 && (w ? tx_won : tx_lost) !== 1'b1; n++) @(posedge hclk);
    if ((w ? tx_won : tx_lost) !== 1'b1) fail("no arbitration event");
  endtask : wev
  task automatic t_regs();
    rd(`CMH_OFF_IMR);
    chk(q, 32'h0000_0000);
    wr(`CMH_OFF_IER, 32'h0000_00FF);
    wr(`CMH_OFF_IDR, 32'h0000_00FE);
    rd(`CMH_OFF_IMR);
    chk(q, 32'h0000_0001);
    rd(12'h100);
    chk(q, 32'h0000_0000);
    $display("regs done");
  endtask : t_regs
  task automatic t_rx();
    mode(0, CMH_MOT_RX, 4'hF);
    mode(1, CMH_MOT_RXOVR, 4'h0);
    u_eng.rx(8'h03, 1'b0, 64'h1111_2222_3333_4444);
    st(0, 3'b010, 3'b011);
    st(1, 3'b000, 3'b011);
    u_eng.rx(8'h03, 1'b0, 64'h5555_6666_7777_8888);
    st(1, 3'b010, 3'b011);
    u_eng.rx(8'h03, 1'b0, 64'h9999_AAAA_BBBB_CCCC);
    st(1, 3'b110, 3'b111);
    st(1, 3'b010, 3'b111);
    rd(ma(0, `CMH_MB_MDL));
    chk(q, 32'h3333_4444);
    rd(ma(1, `CMH_MB_MDH));
    chk(q, 32'h9999_AAAA);
    chk({24'h0, mb_irq}, 32'h0000_0001);
    wr(ma(0, `CMH_MB_MCR), 32'h0088_0000);
    st(0, 3'b000, 3'b011);
    chk({24'h0, mb_irq}, 32'h0000_0000);
    $display("rx chaining done");
  endtask : t_rx
  task automatic t_tx();
    int ord[4] = '{6, 7, 2, 3};
    u_eng.log_q.delete();
    mode(2, CMH_MOT_TX, 4'h5);
    mode(3, CMH_MOT_TX, 4'h5);
    mode(6, CMH_MOT_TX, 4'h1);
    mode(7, CMH_MOT_TX, 4'h1);
    st(2, 3'b010, 3'b011);
    wr(`CMH_OFF_TCR, 32'h0000_00CC);
    st(2, 3'b000, 3'b011);
    wl(4);
    for (int i = 0; i < 4; i++) chk({29'h0, u_eng.log_q[i][2:0]}, 32'(ord[i]));
    st(2, 3'b010, 3'b011);
    $display("tx priority done");
  endtask : t_tx
  task automatic t_retry();
    u_eng.log_q.delete();
    mode(4, CMH_MOT_TX, 4'h0);
    u_eng.lose_n = 1;
    wr(ma(4, `CMH_MB_MCR), 32'h0090_0000);
    wl(1);
    chk({28'h0, u_eng.log_q[0]}, 32'h0000_000C);
    st(4, 3'b010, 3'b011);
    wr(`CMH_OFF_MR, 32'h0000_0080);
    u_eng.lose_n = 1;
    wr(ma(4, `CMH_MB_MCR), 32'h0088_0000);
    wev(1'b0);
    st(4, 3'b011, 3'b011);
    chk(32'(u_eng.log_q.size()), 32'h0000_0001);
    mode(5, CMH_MOT_TX, 4'h0);
    u_eng.dly = 12;
    wr(`CMH_OFF_TCR, 32'h0000_0030);
    wev(1'b1);
    wr(`CMH_OFF_ACR, 32'h0000_0030);
    st(4, 3'b010, 3'b011);
    st(5, 3'b011, 3'b011);
    wl(2);
    u_eng.dly = 3;
    $display("retry and abort done");
  endtask : t_retry
  task automatic t_rem();
    u_eng.log_q.delete();
    mode(0, CMH_MOT_PROD, 4'h0);
    st(0, 3'b010, 3'b011);
    u_eng.rx(8'h01, 1'b1, 64'h0000_0000_0000_0000);
    st(0, 3'b110, 3'b111);
    st(0, 3'b010, 3'b111);
    wr(ma(0, `CMH_MB_MDL), 32'hA5A5_0001);
    wr(ma(0, `CMH_MB_MCR), 32'h0088_0000);
    repeat (20) @(posedge hclk);
    chk(32'(u_eng.log_q.size()), 32'h0000_0000);
    u_eng.rx(8'h01, 1'b1, 64'h0000_0000_0000_0000);
    wl(1);
    chk({29'h0, u_eng.log_q[0][2:0]}, 32'h0000_0000);
    mode(1, CMH_MOT_CONS, 4'h0);
    st(1, 3'b000, 3'b011);
    wr(`CMH_OFF_TCR, 32'h0000_0002);
    wl(2);
    chk({28'h0, u_eng.log_q[1]}, 32'h0000_0009);
    u_eng.rx(8'h02, 1'b0, 64'h0101_0202_0303_0404);
    st(1, 3'b010, 3'b111);
    u_eng.rx(8'h02, 1'b0, 64'h0505_0606_0707_0808);
    st(1, 3'b110, 3'b111);
    rd(ma(1, `CMH_MB_MDL));
    chk(q, 32'h0303_0404);
    st(1, 3'b010, 3'b111);
    mode(2, CMH_MOT_RXOVR, 4'h0);
    u_eng.rx(8'h06, 1'b0, 64'h0909_0A0A_0B0B_0C0C);
    st(1, 3'b010, 3'b111);
    st(2, 3'b010, 3'b011);
    $display("remote frames done");
  endtask : t_rem
  // reset, then every scenario in turn
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    t_retry();
    t_rem();
    conclude();
  end
endmodule : tb_can_mailbox_message_handler
